// ==== sim/mbx_exec_chk.sv ====
// port assertions for the bit-op and transfer executor
// assumes binding into every executor instance
`timescale 1ns/1ns
`default_nettype none
module mbx_exec_chk (
	input wire logic clock,
	input wire logic resetn,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire logic [4:0] issue_op,
	input wire logic [2:0] issue_bit,
	input wire logic dmem_rd,
	input wire logic dmem_wr,
	input wire logic [15:0] dmem_addr,
	input wire logic pmem_rd,
	input wire logic [7:0] cpu_flag_register,
	input wire logic [15:0] stack_ptr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// an instruction is accepted at this edge
	wire logic take;
	assign take = issue_valid && issue_ready;
	sequence s_mem_wait;
		!issue_ready ##1 issue_ready;
	endsequence
	sequence s_prog_wait;
		!issue_ready [*2] ##1 issue_ready;
	endsequence
	AST_MEM_TWO: assert property (take && (dmem_rd || dmem_wr) |=> s_mem_wait)
		else $error("memory op not two cycles");
	AST_PROG_THREE: assert property (take && pmem_rd |=> s_prog_wait)
		else $error("program read not three cycles");
	AST_HOLD_ISSUE: assert property (!issue_ready |-> !dmem_rd && !dmem_wr && !pmem_rd)
		else $error("strobe while busy");
	AST_SWAP_FLAGS: assert property (take && issue_op == mbx_pkg::MBX_OP_SWAP |=> $stable(cpu_flag_register))
		else $error("swap changed flags");
	AST_MOVE_FLAGS: assert property (take && issue_op == mbx_pkg::MBX_OP_MOV |=> $stable(cpu_flag_register))
		else $error("move changed flags");
	AST_FLAG_SET: assert property (take && issue_op == mbx_pkg::MBX_OP_BSET |=> cpu_flag_register == ($past(cpu_flag_register) | (8'h01 << $past(issue_bit))))
		else $error("flag set wrong");
	AST_FLAG_CLR: assert property (take && issue_op == mbx_pkg::MBX_OP_BCLR |=> cpu_flag_register == ($past(cpu_flag_register) & ~(8'h01 << $past(issue_bit))))
		else $error("flag clear wrong");
	AST_BIT_TO_T: assert property (take && issue_op == mbx_pkg::MBX_OP_BTOF |=> ((cpu_flag_register ^ $past(cpu_flag_register)) & 8'hBF) == 8'h00)
		else $error("bit store touched other flags");
	AST_PUSH: assert property (take && issue_op == mbx_pkg::MBX_OP_PUSH |-> dmem_wr && dmem_addr == stack_ptr ##1 stack_ptr == $past(stack_ptr) - 16'h0001)
		else $error("push address or pointer wrong");
endmodule
bind mbx_exec mbx_exec_chk u_mbx_exec_chk (.clock, .resetn, .issue_valid,
	.issue_ready, .issue_op, .issue_bit, .dmem_rd, .dmem_wr, .dmem_addr,
	.pmem_rd, .cpu_flag_register, .stack_ptr);
`default_nettype wire

// ==== sim/mbx_mem_model.sv ====
// data, program and port memory on the far side of the executor
// assumes one-cycle read latency on data and program memory
`timescale 1ns/1ns
`default_nettype none
module mbx_mem_model (
	input wire logic clock,
	input wire logic dmem_rd,
	input wire logic dmem_wr,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	output logic [7:0] dmem_rdata,
	input wire logic pmem_rd,
	input wire logic [15:0] pmem_addr,
	output logic [7:0] pmem_rdata,
	input wire logic io_rd,
	input wire logic [5:0] io_addr,
	output logic [7:0] io_rdata
);
	logic [7:0] mem [256];
	// address-unique fill so every load has a known answer
	initial begin
		dmem_rdata = 8'h00;
		pmem_rdata = 8'h00;
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'h3C;
	end
	// read data valid one cycle only; flipped after so stale use shows
	always @(posedge clock) begin
		dmem_rdata <= dmem_rd ? mem[dmem_addr[7:0]] : ~dmem_rdata;
		pmem_rdata <= pmem_rd ? pmem_addr[7:0] ^ 8'hC3 : ~pmem_rdata;
		if (dmem_wr)
			mem[dmem_addr[7:0]] <= dmem_wdata;
	end
	// port reads answer in the strobe cycle, inverted otherwise
	assign io_rdata = io_rd ? {2'h0, io_addr} : ~{2'h0, io_addr};
endmodule
`default_nettype wire

// ==== sim/tb_mbx_exec.sv ====
// self-checking bench for the bit-op and transfer executor
// assumes the memory model answers data, program and port reads
`timescale 1ns/1ns
`default_nettype none
module tb_mbx_exec;
	logic clock, resetn, issue_valid, issue_ready;
	logic [4:0] issue_op, issue_rd, issue_rr, peek_sel;
	logic [2:0] issue_bit;
	logic [1:0] issue_ptr;
	logic [5:0] issue_disp, io_addr;
	logic [15:0] issue_addr, dmem_addr, pmem_addr, pmem_wdata, stack_ptr;
	logic dmem_rd, dmem_wr, pmem_rd, pmem_wr, io_rd;
	logic [7:0] dmem_wdata, dmem_rdata, pmem_rdata, io_rdata;
	logic [7:0] cpu_flag_register, reg_peek;
	logic [31:0] pw;
	logic [15:0] po;
	logic io_wr;
	logic [7:0] io_wdata;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	mbx_exec u_mbx_exec (.clock, .resetn, .issue_valid, .issue_ready,
		.issue_op, .issue_rd, .issue_rr, .issue_bit, .issue_ptr, .issue_disp,
		.issue_addr, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .dmem_rdata,
		.pmem_rd, .pmem_wr, .pmem_addr, .pmem_wdata, .pmem_rdata, .io_rd,
		.io_wr, .io_addr, .io_wdata, .io_rdata, .cpu_flag_register,
		.stack_ptr, .reg_peek, .peek_sel);
	mbx_mem_model u_mbx_mem_model (.clock, .dmem_rd, .dmem_wr, .dmem_addr,
		.dmem_wdata, .dmem_rdata, .pmem_rd, .pmem_addr, .pmem_rdata, .io_rd,
		.io_addr, .io_rdata);
	// 25 MHz core clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// hang guard; also latch the last program-memory write
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (pmem_wr === 1'b1)
			pw <= {pmem_addr, pmem_wdata};
		if (io_wr === 1'b1)
			po <= {2'h0, io_addr, io_wdata};
		if (cyc == 2000) begin
			bad_count++;
			test_done;
		end
	end
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pk(input logic [4:0] s, input logic [7:0] e);
		peek_sel <= s;
		@(posedge clock);
		chk({8'h00, reg_peek}, {8'h00, e});
	endtask
	task automatic fl(input logic [7:0] e);
		chk({8'h00, cpu_flag_register}, {8'h00, e});
	endtask
	// offer one instruction, hold it until taken, wait for idle again
	task automatic ex(input logic [4:0] op, rd, rr, input logic [15:0] x);
		issue_op <= op;
		issue_rd <= rd;
		issue_rr <= rr;
		issue_bit <= x[2:0];
		issue_ptr <= x[9:8];
		issue_disp <= x[5:0];
		issue_addr <= x;
		issue_valid <= 1'b1;
		do @(posedge clock); while (issue_ready !== 1'b1);
		issue_valid <= 1'b0;
		#1;
		while (issue_ready !== 1'b1) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
	endtask
	initial begin
		resetn = 1'b0;
		issue_valid = 1'b0;
		ex_init();
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		chk(stack_ptr, 16'h01FF);
		for (int i = 0; i < 8; i++) begin
			ex(mbx_pkg::MBX_OP_BSET, 5'h00, 5'h00, 16'(i));
		end
		fl(8'hFF);
		for (int i = 0; i < 8; i++) begin
			ex(mbx_pkg::MBX_OP_BCLR, 5'h00, 5'h00, 16'(i));
		end
		fl(8'h00);
		ex(mbx_pkg::MBX_OP_BSET, 5'h00, 5'h00, 16'h0000);
		ex(mbx_pkg::MBX_OP_IN, 5'h10, 5'h10, 16'h0021);
		pk(5'h10, 8'h21);
		ex(mbx_pkg::MBX_OP_ROR, 5'h10, 5'h10, 16'h0000);
		pk(5'h10, 8'h90);
		fl(8'h05);
		ex(mbx_pkg::MBX_OP_ASR, 5'h10, 5'h10, 16'h0000);
		pk(5'h10, 8'hC8);
		fl(8'h0C);
		ex(mbx_pkg::MBX_OP_SWAP, 5'h10, 5'h10, 16'h0000);
		pk(5'h10, 8'h8C);
		ex(mbx_pkg::MBX_OP_BTOF, 5'h10, 5'h10, 16'h0003);
		fl(8'h4C);
		ex(mbx_pkg::MBX_OP_FTOB, 5'h11, 5'h11, 16'h0007);
		pk(5'h11, 8'h80);
		ex(mbx_pkg::MBX_OP_MOV, 5'h12, 5'h10, 16'h0000);
		pk(5'h12, 8'h8C);
		ex(mbx_pkg::MBX_OP_IN, 5'h1A, 5'h1A, 16'h0010);
		ex(mbx_pkg::MBX_OP_LDINC, 5'h13, 5'h13, 16'h0000);
		pk(5'h13, 8'h2C);
		pk(5'h1A, 8'h11);
		ex(mbx_pkg::MBX_OP_STDEC, 5'h10, 5'h10, 16'h0000);
		pk(5'h1A, 8'h10);
		ex(mbx_pkg::MBX_OP_LD, 5'h14, 5'h14, 16'h0000);
		pk(5'h14, 8'h8C);
		ex(mbx_pkg::MBX_OP_LDDEC, 5'h15, 5'h15, 16'h0000);
		pk(5'h15, 8'h33);
		pk(5'h1A, 8'h0F);
		ex(mbx_pkg::MBX_OP_STINC, 5'h11, 5'h11, 16'h0000);
		pk(5'h1A, 8'h10);
		ex(mbx_pkg::MBX_OP_LDDEC, 5'h15, 5'h15, 16'h0000);
		pk(5'h15, 8'h80);
		ex(mbx_pkg::MBX_OP_STDIR, 5'h12, 5'h12, 16'h0020);
		ex(mbx_pkg::MBX_OP_LDDIR, 5'h16, 5'h16, 16'h0020);
		pk(5'h16, 8'h8C);
		ex(mbx_pkg::MBX_OP_IN, 5'h1C, 5'h1C, 16'h0008);
		ex(mbx_pkg::MBX_OP_STDISP, 5'h11, 5'h11, 16'h0105);
		ex(mbx_pkg::MBX_OP_LDDISP, 5'h17, 5'h17, 16'h0105);
		pk(5'h17, 8'h80);
		pk(5'h1C, 8'h08);
		ex(mbx_pkg::MBX_OP_PUSH, 5'h10, 5'h10, 16'h0000);
		chk(stack_ptr, 16'h01FE);
		ex(mbx_pkg::MBX_OP_POP, 5'h18, 5'h18, 16'h0000);
		pk(5'h18, 8'h8C);
		chk(stack_ptr, 16'h01FF);
		fl(8'h4C);
		ex(mbx_pkg::MBX_OP_IN, 5'h1E, 5'h1E, 16'h0004);
		ex(mbx_pkg::MBX_OP_PRDINC, 5'h19, 5'h19, 16'h0200);
		pk(5'h19, 8'hC7);
		ex(mbx_pkg::MBX_OP_PRD0, 5'h00, 5'h00, 16'h0200);
		pk(5'h00, 8'hC6);
		ex(mbx_pkg::MBX_OP_PRD, 5'h0F, 5'h0F, 16'h0200);
		pk(5'h0F, 8'hC6);
		pk(5'h1E, 8'h05);
		ex(mbx_pkg::MBX_OP_PWR, 5'h00, 5'h00, 16'h0200);
		chk(pw[31:16], 16'h0005);
		chk(pw[15:0], 16'h00C6);
		ex(mbx_pkg::MBX_OP_OUT, 5'h00, 5'h10, 16'h0015);
		chk(po, 16'h158C);
		test_done;
	end
	// quiet values for every issue input except issue_valid at time zero
	function automatic void ex_init();
		issue_op = 5'h00;
		issue_rd = 5'h00;
		issue_rr = 5'h00;
		issue_bit = 3'h0;
		issue_ptr = 2'h0;
		issue_disp = 6'h00;
		issue_addr = 16'h0000;
		peek_sel = 5'h00;
	endfunction
endmodule
`default_nettype wire

// ==== src/mbx_cfg.svh ====
// constants for the bit-op and transfer executor
// assumes inclusion by the executor module only
`ifndef MBX_CFG_SVH
`define MBX_CFG_SVH
`define MBX_FLAG_C 3'd0
`define MBX_FLAG_Z 3'd1
`define MBX_FLAG_N 3'd2
`define MBX_FLAG_V 3'd3
`define MBX_FLAG_S 3'd4
`define MBX_FLAG_H 3'd5
`define MBX_FLAG_T 3'd6
`define MBX_FLAG_I 3'd7
`define MBX_FLAGS_RST 8'h00
`define MBX_SP_RST 16'h01FF
`define MBX_CYC_MEM 2'd2
`define MBX_CYC_PROG 2'd3
`define MBX_CYC_ONE 2'd1
`endif

// ==== src/mbx_exec.sv ====
// executor for bit, flag and transfer instructions of an 8-bit core
// assumes single-port data memory answering one cycle after a read strobe,
// program memory answering one cycle after its read strobe; same clock.
//
// What this block does
// RL1: rotate right through carry, updates Z C N V, one cycle.
// RL2: arithmetic shift right keeps bit 7, updates Z C N V, one cycle.
// RL3: swap nibbles of a register in one cycle, flags untouched.
// RL4: copy chosen register bit into transfer flag, one cycle.
// RL5: copy transfer flag into chosen register bit, one cycle, no flags.
// RL6: set or clear any single status flag in one cycle.
// RL7: register move in one cycle, no flag change.
// RL8: post-increment indirect load, read then pointer plus one, two cycles.
// RL9: pre-decrement indirect load, pointer minus one then read, two cycles.
// RL10: displaced load from pointer plus displacement, pointer kept, two cycles.
// RL11: direct load from absolute address, two cycles.
// RL12: post-increment indirect store, write then pointer plus one, two cycles.
// RL13: pre-decrement indirect store, pointer minus one then write, two cycles.
// RL14: displaced store to pointer plus displacement, pointer kept, two cycles.
// RL15: direct store to absolute address, two cycles.
// RL16: program-memory load by third pointer, optional increment, three cycles.
// RL17: program-memory store writes registers one:zero at third pointer.
// RL18: push and pop one byte in two cycles each, flags untouched.
// RL19: port in and out move one byte in one cycle, no flags.
// RL20: hold new issue until the last cycle of the current instruction has ended.
`include "mbx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mbx_exec #(
	parameter int ADDR_W = 16,
	parameter int NREG = 32
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire logic [4:0] issue_op,
	input wire logic [4:0] issue_rd,
	input wire logic [4:0] issue_rr,
	input wire logic [2:0] issue_bit,
	input wire logic [1:0] issue_ptr,
	input wire logic [5:0] issue_disp,
	input wire logic [15:0] issue_addr,
	output logic dmem_rd,
	output logic dmem_wr,
	output logic [15:0] dmem_addr,
	output logic [7:0] dmem_wdata,
	input wire logic [7:0] dmem_rdata,
	output logic pmem_rd,
	output logic pmem_wr,
	output logic [15:0] pmem_addr,
	output logic [15:0] pmem_wdata,
	input wire logic [7:0] pmem_rdata,
	output logic io_rd,
	output logic io_wr,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	output logic [7:0] cpu_flag_register,
	output logic [15:0] stack_ptr,
	output logic [7:0] reg_peek,
	input wire logic [4:0] peek_sel
);
	// elaboration check: the pointer pairs and the 16-bit buses assume these
	// sizes, so any other value would silently alias registers or addresses
	if (ADDR_W != 16 || NREG != 32) begin : g_size_chk
		$error("mbx_exec: only 16-bit addresses and 32 registers");
	end

	logic [7:0] regs_r [NREG];
	logic [7:0] flags_r;
	logic [15:0] sp_r;
	mbx_pkg::mbx_state_t state_r;
	logic [1:0] cnt_r;
	logic [4:0] dst_r;
	logic ld_pend_r;

	// operand fetch and decode
	wire take = issue_valid && issue_ready;
	wire mbx_pkg::mbx_op_t op = mbx_pkg::mbx_op_t'(issue_op);
	wire [7:0] rd_v = regs_r[issue_rd];
	wire [7:0] rr_v = regs_r[issue_rr];
	wire [4:0] plo = 5'd26 + {2'b00, issue_ptr, 1'b0};
	wire [4:0] phi = plo + 5'd1;
	wire [15:0] ptr = {regs_r[phi], regs_r[plo]};
	wire [15:0] ptr_inc = ptr + 16'h0001;
	wire [15:0] ptr_dec = ptr - 16'h0001;
	wire [15:0] ptr_disp = ptr + {10'h000, issue_disp};
	wire [15:0] zptr = {regs_r[31], regs_r[30]};
	wire c_in = flags_r[`MBX_FLAG_C];
	wire t_in = flags_r[`MBX_FLAG_T];

	// shift results; V is N xor C as for any right shift
	wire [7:0] ror_res = {c_in, rd_v[7:1]}; // RL1
	wire [7:0] asr_res = {rd_v[7], rd_v[7:1]}; // RL2
	wire [7:0] sh_res = (op == mbx_pkg::MBX_OP_ROR) ? ror_res : asr_res;
	wire sh_c = rd_v[0];
	wire sh_n = sh_res[7];
	wire sh_z = (sh_res == 8'h00);
	wire sh_v = sh_n ^ sh_c;

	// pointer update class of a memory op
	wire is_inc = (op == mbx_pkg::MBX_OP_LDINC) ||
		(op == mbx_pkg::MBX_OP_STINC);
	wire is_dec = (op == mbx_pkg::MBX_OP_LDDEC) ||
		(op == mbx_pkg::MBX_OP_STDEC);
	wire is_load = (op == mbx_pkg::MBX_OP_LD) || (op == mbx_pkg::MBX_OP_LDINC)
		|| (op == mbx_pkg::MBX_OP_LDDEC) || (op == mbx_pkg::MBX_OP_LDDISP)
		|| (op == mbx_pkg::MBX_OP_LDDIR) || (op == mbx_pkg::MBX_OP_POP);
	wire is_store = (op == mbx_pkg::MBX_OP_ST) ||
		(op == mbx_pkg::MBX_OP_STINC) || (op == mbx_pkg::MBX_OP_STDEC) ||
		(op == mbx_pkg::MBX_OP_STDISP) || (op == mbx_pkg::MBX_OP_STDIR) ||
		(op == mbx_pkg::MBX_OP_PUSH);
	wire is_prd = (op == mbx_pkg::MBX_OP_PRD0) ||
		(op == mbx_pkg::MBX_OP_PRD) || (op == mbx_pkg::MBX_OP_PRDINC);

	// data memory address per addressing form
	logic [15:0] mem_a;
	always_comb begin
		case (op)
			mbx_pkg::MBX_OP_LDDEC, mbx_pkg::MBX_OP_STDEC:
				mem_a = ptr_dec; // RL9 RL13
			mbx_pkg::MBX_OP_LDDISP, mbx_pkg::MBX_OP_STDISP:
				mem_a = ptr_disp; // RL10 RL14
			mbx_pkg::MBX_OP_LDDIR, mbx_pkg::MBX_OP_STDIR:
				mem_a = issue_addr; // RL11 RL15
			mbx_pkg::MBX_OP_PUSH:
				mem_a = sp_r;
			mbx_pkg::MBX_OP_POP:
				mem_a = sp_r + 16'h0001;
			default:
				mem_a = ptr;
		endcase
	end

	// new issue only when idle; multi-cycle ops block it
	assign issue_ready = (state_r == mbx_pkg::MBX_ST_IDLE); // RL20

	// sequencer: counts the remaining cycles of a memory op
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= mbx_pkg::MBX_ST_IDLE;
			cnt_r <= 2'd0;
			dst_r <= 5'd0;
			ld_pend_r <= 1'b0;
		end else begin
			case (state_r)
				mbx_pkg::MBX_ST_IDLE: begin
					if (take && (is_load || is_store)) begin
						state_r <= mbx_pkg::MBX_ST_MEM;
						cnt_r <= `MBX_CYC_MEM - 2'd1;
						dst_r <= (op == mbx_pkg::MBX_OP_PRD0) ? 5'd0 : issue_rd;
						ld_pend_r <= is_load;
					end else if (take && is_prd) begin
						state_r <= mbx_pkg::MBX_ST_PROG; // RL16
						cnt_r <= `MBX_CYC_PROG - 2'd1;
						dst_r <= (op == mbx_pkg::MBX_OP_PRD0) ? 5'd0 : issue_rd;
						ld_pend_r <= 1'b1;
					end
				end
				mbx_pkg::MBX_ST_MEM, mbx_pkg::MBX_ST_PROG: begin
					cnt_r <= cnt_r - 2'd1;
					if (cnt_r == `MBX_CYC_ONE) begin
						state_r <= mbx_pkg::MBX_ST_IDLE;
						ld_pend_r <= 1'b0;
					end
				end
				default:
					state_r <= mbx_pkg::MBX_ST_IDLE;
			endcase
		end
	end

	// program data arrives on the final cycle; data memory on the second
	wire mem_done = (state_r == mbx_pkg::MBX_ST_MEM) && ld_pend_r;
	wire prog_done = (state_r == mbx_pkg::MBX_ST_PROG) &&
		(cnt_r == `MBX_CYC_ONE);
	wire prog_wait = (state_r == mbx_pkg::MBX_ST_PROG) &&
		(cnt_r != `MBX_CYC_ONE);
	logic [7:0] pbyte_r;

	// program byte capture, one cycle after the read strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			pbyte_r <= 8'h00;
		else if (prog_wait)
			pbyte_r <= pmem_rdata;
	end

	// memory and port strobes: combinational, issued in the take cycle
	always_comb begin
		dmem_rd = take && is_load; // RL8 RL9 RL10 RL11
		dmem_wr = take && is_store; // RL12 RL13 RL14 RL15
		dmem_addr = mem_a;
		dmem_wdata = rr_v;
		pmem_rd = take && is_prd; // RL16
		pmem_wr = take && (op == mbx_pkg::MBX_OP_PWR); // RL17
		pmem_addr = zptr;
		pmem_wdata = {regs_r[1], regs_r[0]}; // RL17
		io_rd = take && (op == mbx_pkg::MBX_OP_IN); // RL19
		io_wr = take && (op == mbx_pkg::MBX_OP_OUT); // RL19
		io_addr = issue_disp;
		io_wdata = rr_v;
	end

	// flag register: single-cycle updates only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flags_r <= `MBX_FLAGS_RST;
		end else if (take) begin
			case (op)
				mbx_pkg::MBX_OP_ROR, mbx_pkg::MBX_OP_ASR: begin
					flags_r[`MBX_FLAG_C] <= sh_c; // RL1 RL2
					flags_r[`MBX_FLAG_Z] <= sh_z;
					flags_r[`MBX_FLAG_N] <= sh_n;
					flags_r[`MBX_FLAG_V] <= sh_v;
				end
				mbx_pkg::MBX_OP_BSET:
					flags_r[issue_bit] <= 1'b1; // RL6
				mbx_pkg::MBX_OP_BCLR:
					flags_r[issue_bit] <= 1'b0; // RL6
				mbx_pkg::MBX_OP_BTOF:
					flags_r[`MBX_FLAG_T] <= rr_v[issue_bit]; // RL4
				default:
					flags_r <= flags_r; // RL3 RL5 RL7 RL18 RL19
			endcase
		end
	end

	// stack pointer: push writes then decrements, pop increments then reads
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			sp_r <= `MBX_SP_RST;
		else if (take && op == mbx_pkg::MBX_OP_PUSH)
			sp_r <= sp_r - 16'h0001; // RL18
		else if (take && op == mbx_pkg::MBX_OP_POP)
			sp_r <= sp_r + 16'h0001; // RL18
	end

	// register results: load data first, then single-cycle results
	logic wr_en;
	logic [4:0] wr_idx;
	logic [7:0] wr_val;
	always_comb begin
		wr_en = 1'b0;
		wr_idx = issue_rd;
		wr_val = rd_v;
		if (mem_done) begin
			wr_en = 1'b1;
			wr_idx = dst_r;
			wr_val = dmem_rdata; // RL8 RL11 RL18
		end else if (prog_done) begin
			wr_en = 1'b1;
			wr_idx = dst_r;
			wr_val = pbyte_r; // RL16
		end else if (take) begin
			case (op)
				mbx_pkg::MBX_OP_ROR, mbx_pkg::MBX_OP_ASR: begin
					wr_en = 1'b1;
					wr_val = sh_res; // RL1 RL2
				end
				mbx_pkg::MBX_OP_SWAP: begin
					wr_en = 1'b1;
					wr_val = {rd_v[3:0], rd_v[7:4]}; // RL3
				end
				mbx_pkg::MBX_OP_FTOB: begin
					wr_en = 1'b1;
					wr_val = rd_v;
					wr_val[issue_bit] = t_in; // RL5
				end
				mbx_pkg::MBX_OP_MOV: begin
					wr_en = 1'b1;
					wr_val = rr_v; // RL7
				end
				mbx_pkg::MBX_OP_IN: begin
					wr_en = 1'b1;
					wr_val = io_rdata; // RL19
				end
				default:
					wr_en = 1'b0;
			endcase
		end
	end

	// pointer write-back in the take cycle; no overlap with result writes
	wire ptr_upd = take && (is_inc || is_dec ||
		op == mbx_pkg::MBX_OP_PRDINC);
	wire [15:0] ptr_new = is_dec ? ptr_dec : ptr_inc; // RL8 RL9 RL12 RL13
	wire [4:0] upd_lo = (op == mbx_pkg::MBX_OP_PRDINC) ? 5'd30 : plo;
	wire [15:0] upd_val = (op == mbx_pkg::MBX_OP_PRDINC) ?
		(zptr + 16'h0001) : ptr_new; // RL16

	// register file, one generate entry per register
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn)
					regs_r[gi] <= 8'h00;
				else if (wr_en && wr_idx == gi[4:0])
					regs_r[gi] <= wr_val;
				else if (ptr_upd && upd_lo == gi[4:0])
					regs_r[gi] <= upd_val[7:0];
				else if (ptr_upd && upd_lo + 5'd1 == gi[4:0])
					regs_r[gi] <= upd_val[15:8];
			end
		end
	endgenerate

	assign cpu_flag_register = flags_r;
	assign stack_ptr = sp_r;
	assign reg_peek = regs_r[peek_sel];
endmodule
`default_nettype wire

// ==== src/mbx_pkg.sv ====
// types shared by the executor and its bench
// assumes the configuration header defines all figures
package mbx_pkg;
	typedef enum logic [4:0] {
		MBX_OP_NOP = 5'h00,
		MBX_OP_ROR = 5'h01,
		MBX_OP_ASR = 5'h02,
		MBX_OP_SWAP = 5'h03,
		MBX_OP_BSET = 5'h04,
		MBX_OP_BCLR = 5'h05,
		MBX_OP_BTOF = 5'h06,
		MBX_OP_FTOB = 5'h07,
		MBX_OP_MOV = 5'h08,
		MBX_OP_LD = 5'h09,
		MBX_OP_LDINC = 5'h0A,
		MBX_OP_LDDEC = 5'h0B,
		MBX_OP_LDDISP = 5'h0C,
		MBX_OP_LDDIR = 5'h0D,
		MBX_OP_ST = 5'h0E,
		MBX_OP_STINC = 5'h0F,
		MBX_OP_STDEC = 5'h10,
		MBX_OP_STDISP = 5'h11,
		MBX_OP_STDIR = 5'h12,
		MBX_OP_PRD0 = 5'h13,
		MBX_OP_PRD = 5'h14,
		MBX_OP_PRDINC = 5'h15,
		MBX_OP_PWR = 5'h16,
		MBX_OP_PUSH = 5'h17,
		MBX_OP_POP = 5'h18,
		MBX_OP_IN = 5'h19,
		MBX_OP_OUT = 5'h1A
	} mbx_op_t;
	typedef enum logic [2:0] {
		MBX_ST_IDLE = 3'b001,
		MBX_ST_MEM = 3'b010,
		MBX_ST_PROG = 3'b100
	} mbx_state_t;
endpackage
